// >>> core/fsps_flash_seq.sv
// Flash self-programming sequencer: holding latches, unlock key, operation control.
// Assumes the core end drives the link; the flash array takes one word per fl_prog_o.
`timescale 1ns/1ps
module fsps_flash_seq (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Link to the core
   fsps_if.flash bus,
   // Flash array side
   output logic [fsps_pkg::ADDR_W-1:0] fl_addr_o,
   output logic [fsps_pkg::WORD_W-1:0] fl_data_o,
   output logic fl_prog_o,
   output logic fl_erase_o,
   output logic cfg_cleared_o,
   output logic op_done_o
);
   import fsps_pkg::*;

   typedef enum logic [1:0] {D_IDLE, D_ROW, D_WAIT} fsps_dst_t;
   typedef enum logic [1:0] {K_IDLE, K_FIRST, K_ARMED} fsps_key_t;

   typedef struct packed {
      fsps_dst_t st;
      fsps_key_t key;
      logic [15:0] ctrl;
      logic [ADDR_W-1:0] target;
      logic tw_phase;
      logic tbl_ack;
      logic stall;
      logic [LAT_IDX_W-1:0] idx;
      logic [ADDR_W-1:0] fl_addr;
      logic [WORD_W-1:0] fl_data;
      logic fl_prog;
      logic fl_erase;
      logic cfg_cleared;
      logic done;
      logic tmr_load;
      logic [TMR_W-1:0] tmr_cnt;
   } fsps_dev_t;

   fsps_dev_t s;
   fsps_dev_t next_s;
   logic [WORD_W-1:0] latch [ROW_WORDS];
   logic lat_we;
   logic [ADDR_W-1:0] word_addr;
   logic [ADDR_W-1:0] row_base;
   logic [ADDR_W-1:0] blk_base;
   logic tmr_done;
   logic [3:0] op;

   // Accept only documented operation selections
   function automatic logic op_ok(input logic [15:0] w);
      logic [3:0] code;
      code = w[3:0];
      op_ok = (code == OP_ERASE && w[ERASE_BIT])
         || (code == OP_ROW && !w[ERASE_BIT])
         || (code == OP_WORD && !w[ERASE_BIT]);
   endfunction : op_ok

   // Word address from page pointer and byte offset
   assign word_addr = {1'b0, bus.table_page_pointer, bus.tbl_offset[15:1]};
   // Aligned bases of the target row and erase block
   assign row_base = {s.target[ADDR_W-1:LAT_IDX_W], LAT_IDX_W'(0)};
   assign blk_base = {s.target[ADDR_W-1:BLK_IDX_W], BLK_IDX_W'(0)};
   assign op = bus.reg_wdata[3:0];

   fsps_timer u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(s.tmr_load),
      .count_i(s.tmr_cnt),
      .done_o(tmr_done)
   );

   // Next-state logic
   always_comb begin
      next_s = s;
      next_s.tbl_ack = 1'b0;
      next_s.fl_prog = 1'b0;
      next_s.fl_erase = 1'b0;
      next_s.done = 1'b0;
      next_s.tmr_load = 1'b0;
      lat_we = 1'b0;

      // Latch load: taken, then acknowledged one cycle later
      if (s.tw_phase) begin
         next_s.tw_phase = 1'b0;
         next_s.tbl_ack = 1'b1;
         lat_we = 1'b1;
         next_s.target = word_addr;
         next_s.key = K_IDLE;
      end else if (bus.tbl_wr && !s.tbl_ack && !s.stall) begin
         next_s.tw_phase = 1'b1;
      end

      // Register writes; none are taken while stalled
      if (bus.reg_wr && !s.stall) begin
         if (bus.reg_sel == REG_KEY) begin
            if (s.key == K_IDLE && bus.reg_wdata == KEY_FIRST) begin
               next_s.key = K_FIRST;
            end else if (s.key == K_FIRST && bus.reg_wdata == KEY_SECOND) begin
               next_s.key = K_ARMED;
            end else begin
               next_s.key = K_IDLE;
            end
         end else begin
            next_s.key = K_IDLE;
            next_s.ctrl = bus.reg_wdata & CTRL_MASK;
            next_s.ctrl[START_BIT] = 1'b0;
            // Launch only when enabled, armed and well formed
            if (bus.reg_wdata[START_BIT] && bus.reg_wdata[OP_WRITE_ENABLE_BIT]
                && s.key == K_ARMED && op_ok(bus.reg_wdata)) begin
               next_s.ctrl[START_BIT] = 1'b1;
               next_s.stall = 1'b1;
               next_s.st = D_WAIT;
               if (op == OP_ERASE) begin
                  // Whole eight-row block at once
                  next_s.fl_erase = 1'b1;
                  next_s.fl_addr = blk_base;
                  next_s.tmr_cnt = ERASE_CYC;
                  next_s.tmr_load = 1'b1;
                  if (blk_base == LAST_BLOCK) begin
                     next_s.cfg_cleared = 1'b1;
                  end
               end else if (op == OP_ROW) begin
                  next_s.st = D_ROW;
                  next_s.idx = '0;
               end else begin
                  // Single word from its own latch
                  next_s.fl_prog = 1'b1;
                  next_s.fl_addr = s.target;
                  next_s.fl_data = latch[s.target[LAT_IDX_W-1:0]];
                  next_s.tmr_cnt = WORD_CYC;
                  next_s.tmr_load = 1'b1;
               end
            end
         end
      end

      // Operation sequencing
      case (s.st)
         D_ROW: begin
            // All 64 latches go out whatever was loaded
            next_s.fl_prog = 1'b1;
            next_s.fl_addr = row_base | ADDR_W'(s.idx);
            next_s.fl_data = latch[s.idx];
            next_s.idx = s.idx + LAT_IDX_W'(1);
            if (s.idx == LAT_IDX_W'(ROW_WORDS - 1)) begin
               next_s.tmr_cnt = ROW_CYC;
               next_s.tmr_load = 1'b1;
               next_s.st = D_WAIT;
            end
         end
         D_WAIT: begin
            if (tmr_done) begin
               next_s.ctrl[START_BIT] = 1'b0;
               next_s.stall = 1'b0;
               next_s.done = 1'b1;
               next_s.st = D_IDLE;
            end
         end
         default: begin
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.st <= D_IDLE;
         s.key <= K_IDLE;
         s.ctrl <= CTRL_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Holding latches, deliberately not reset
   always_ff @(posedge clk_i) begin
      if (lat_we) begin
         latch[word_addr[LAT_IDX_W-1:0]] <= bus.tbl_data;
      end
   end

   // Outputs from registers
   assign bus.tbl_ack = s.tbl_ack;
   assign bus.ctrl_rdata = s.ctrl;
   assign bus.stall = s.stall;
   assign fl_addr_o = s.fl_addr;
   assign fl_data_o = s.fl_data;
   assign fl_prog_o = s.fl_prog;
   assign fl_erase_o = s.fl_erase;
   assign cfg_cleared_o = s.cfg_cleared;
   assign op_done_o = s.done;
endmodule : fsps_flash_seq

// >>> core/fsps_pkg.sv
// Shared constants for the flash self-programming sequencer and its core-side end.
// Assumes a single 50 MHz system clock and one instruction cycle per clock.
package fsps_pkg;
   // Array geometry, counted in instruction words of 3 bytes
   localparam int WORD_W = 24;
   localparam int ADDR_W = 24;
   localparam int BYTES_PER_WORD = 3;
   localparam int ROW_WORDS = 64;
   localparam int ROW_BYTES = 192;
   localparam int BLOCK_ROWS = 8;
   localparam int BLOCK_WORDS = 512;
   localparam int BLOCK_BYTES = 1536;
   localparam int LAT_IDX_W = 6;
   localparam int BLK_IDX_W = 9;
   localparam int PM_WORDS = 4096;
   localparam logic [ADDR_W-1:0] LAST_BLOCK = ADDR_W'(PM_WORDS - BLOCK_WORDS);
   localparam logic [WORD_W-1:0] LATCH_FILL = 24'h0FFFFF;
   // Operation control register fields
   localparam int START_BIT = 15;
   localparam int OP_WRITE_ENABLE_BIT = 14;
   localparam int ERASE_BIT = 6;
   localparam logic [15:0] CTRL_MASK = 16'hC04F;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [3:0] OP_ROW = 4'h1;
   localparam logic [3:0] OP_ERASE = 4'h2;
   localparam logic [3:0] OP_WORD = 4'h3;
   // Unlock key values and register select
   localparam logic [15:0] KEY_FIRST = 16'h0055;
   localparam logic [15:0] KEY_SECOND = 16'h00AA;
   localparam logic REG_CTRL = 1'b0;
   localparam logic REG_KEY = 1'b1;
   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int ERASE_TIME_NS = 40000;
   localparam int ROW_TIME_NS = 20000;
   localparam int WORD_TIME_NS = 10000;
   localparam int TMR_W = 12;
   localparam logic [TMR_W-1:0] ERASE_CYC =
      TMR_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] ROW_CYC =
      TMR_W'((ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] WORD_CYC =
      TMR_W'((WORD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] NOP_SLOTS = 2'h2;
   // Core-side Wishbone register map and commands
   localparam logic [7:0] HREG_CMD = 8'h00;
   localparam logic [7:0] HREG_ADDR = 8'h04;
   localparam logic [7:0] HREG_DATA = 8'h08;
   localparam logic [7:0] HREG_STATUS = 8'h0C;
   localparam logic [2:0] HCMD_LOAD = 3'h1;
   localparam logic [2:0] HCMD_ERASE = 3'h2;
   localparam logic [2:0] HCMD_ROW = 3'h3;
   localparam logic [2:0] HCMD_WORD = 3'h4;
endpackage : fsps_pkg

// >>> core/fsps_if.sv
// Link between the processor core end and the flash sequencer end.
// Assumes both ends share clk_i; the bench instantiates and joins them.
`timescale 1ns/1ps
interface fsps_if;
   // Table write: held until acknowledged
   logic tbl_wr;
   logic [7:0] table_page_pointer;
   logic [15:0] tbl_offset;
   logic [fsps_pkg::WORD_W-1:0] tbl_data;
   logic tbl_ack;
   // Register writes, one-cycle pulses
   logic reg_wr;
   logic reg_sel;
   logic [15:0] reg_wdata;
   logic [15:0] ctrl_rdata;
   logic stall;
   modport core (output tbl_wr, table_page_pointer, tbl_offset, tbl_data, reg_wr, reg_sel,
      reg_wdata, input tbl_ack, ctrl_rdata, stall);
   modport flash (input tbl_wr, table_page_pointer, tbl_offset, tbl_data, reg_wr, reg_sel,
      reg_wdata, output tbl_ack, ctrl_rdata, stall);
endinterface : fsps_if

// >>> core/fsps_timer.sv
// Cycle timer for erase and program durations.
// Assumes load_i is a one-cycle pulse and count_i is at least one.
`timescale 1ns/1ps
module fsps_timer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic load_i,
   input wire logic [fsps_pkg::TMR_W-1:0] count_i,
   output logic done_o
);
   import fsps_pkg::*;

   typedef struct packed {
      logic run;
      logic [TMR_W-1:0] cnt;
      logic done;
   } fsps_tmr_t;

   fsps_tmr_t s;
   fsps_tmr_t next_s;

   // Count down, pulse done on the last cycle
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (load_i) begin
         next_s.run = 1'b1;
         next_s.cnt = count_i;
      end else if (s.run) begin
         if (s.cnt <= TMR_W'(1)) begin
            next_s.run = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.cnt = s.cnt - TMR_W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done_o = s.done;
endmodule : fsps_timer

// >>> core/fsps_core_host.sv
// Core-side end: runs latch loads and unlock/start sequences on Wishbone command.
// Assumes a classic Wishbone master and the sequencer end on the link.
`timescale 1ns/1ps
module fsps_core_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Link to the sequencer
   fsps_if.core bus
);
   import fsps_pkg::*;

   typedef enum logic [2:0] {H_IDLE, H_CFG, H_TBLW, H_KEY1, H_KEY2, H_GO, H_NOP, H_WAIT
   } fsps_hst_t;

   typedef struct packed {
      fsps_hst_t st;
      logic [2:0] cmd;
      logic [23:0] addr;
      logic [WORD_W-1:0] data;
      logic [15:0] cfg;
      logic after_tbl;
      logic [1:0] nop_cnt;
      logic saw_stall;
      logic refused;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic tbl_wr;
      logic reg_wr;
      logic reg_sel;
      logic [15:0] reg_wdata;
   } fsps_host_t;

   fsps_host_t s;
   fsps_host_t next_s;
   logic [15:0] cfg_sel;

   // Control word for the commanded operation
   always_comb begin
      cfg_sel = 16'h0000;
      cfg_sel[OP_WRITE_ENABLE_BIT] = 1'b1;
      if (wb_dat_i[2:0] == HCMD_ERASE) begin
         cfg_sel[3:0] = OP_ERASE;
         cfg_sel[ERASE_BIT] = 1'b1;
      end else if (wb_dat_i[2:0] == HCMD_ROW) begin
         cfg_sel[3:0] = OP_ROW;
      end else begin
         cfg_sel[3:0] = OP_WORD;
      end
   end

   // Next-state logic
   always_comb begin
      next_s = s;
      next_s.wb_ack = 1'b0;
      next_s.reg_wr = 1'b0;

      // Wishbone: answer one cycle after the strobe
      if (wb_cyc_i && wb_stb_i && !s.wb_ack) begin
         next_s.wb_ack = 1'b1;
         next_s.wb_dat = 32'h00000000;
         if (wb_we_i) begin
            if (wb_adr_i == HREG_CMD) begin
               if (s.st == H_IDLE && wb_sel_i[0]) begin
                  next_s.cmd = wb_dat_i[2:0];
                  next_s.cfg = cfg_sel;
                  next_s.saw_stall = 1'b0;
                  if (wb_dat_i[2:0] == HCMD_LOAD) begin
                     next_s.st = H_TBLW;
                     next_s.tbl_wr = 1'b1;
                     next_s.after_tbl = 1'b0;
                  end else if (wb_dat_i[2:0] != 3'h0 && wb_dat_i[2:0] <= HCMD_WORD) begin
                     next_s.st = H_CFG;
                  end
               end
            end else if (wb_adr_i == HREG_ADDR && s.st == H_IDLE) begin
               for (int b = 0; b < 3; b++) begin
                  if (wb_sel_i[b]) next_s.addr[8*b +: 8] = wb_dat_i[8*b +: 8];
               end
            end else if (wb_adr_i == HREG_DATA && s.st == H_IDLE) begin
               for (int b = 0; b < 3; b++) begin
                  if (wb_sel_i[b]) next_s.data[8*b +: 8] = wb_dat_i[8*b +: 8];
               end
            end
         end else if (wb_adr_i == HREG_ADDR) begin
            next_s.wb_dat = {8'h00, s.addr};
         end else if (wb_adr_i == HREG_DATA) begin
            next_s.wb_dat = {8'h00, s.data};
         end else if (wb_adr_i == HREG_STATUS) begin
            next_s.wb_dat = {bus.ctrl_rdata, 13'h0000, s.refused, bus.stall,
               s.st != H_IDLE};
         end
      end

      // Link sequencing
      case (s.st)
         H_CFG: begin
            next_s.reg_wr = 1'b1;
            next_s.reg_sel = REG_CTRL;
            next_s.reg_wdata = s.cfg;
            if (s.cmd == HCMD_ERASE) begin
               // Target address goes in by a table write
               next_s.st = H_TBLW;
               next_s.tbl_wr = 1'b1;
               next_s.after_tbl = 1'b1;
            end else begin
               next_s.st = H_KEY1;
            end
         end
         H_TBLW: begin
            if (bus.tbl_ack) begin
               next_s.tbl_wr = 1'b0;
               next_s.st = s.after_tbl ? H_KEY1 : H_IDLE;
            end
         end
         H_KEY1: begin
            next_s.reg_wr = 1'b1;
            next_s.reg_sel = REG_KEY;
            next_s.reg_wdata = KEY_FIRST;
            next_s.st = H_KEY2;
         end
         H_KEY2: begin
            next_s.reg_wr = 1'b1;
            next_s.reg_sel = REG_KEY;
            next_s.reg_wdata = KEY_SECOND;
            next_s.st = H_GO;
         end
         H_GO: begin
            next_s.reg_wr = 1'b1;
            next_s.reg_sel = REG_CTRL;
            next_s.reg_wdata = s.cfg | 16'h8000;
            next_s.nop_cnt = NOP_SLOTS - 2'h1;
            next_s.st = H_NOP;
         end
         H_NOP: begin
            // Two idle slots after the start write
            if (bus.stall) next_s.saw_stall = 1'b1;
            if (s.nop_cnt == 2'h0) begin
               next_s.st = H_WAIT;
            end else begin
               next_s.nop_cnt = s.nop_cnt - 2'h1;
            end
         end
         H_WAIT: begin
            // Hold while the sequencer stalls us
            if (bus.stall) begin
               next_s.saw_stall = 1'b1;
            end else begin
               next_s.refused = !s.saw_stall;
               next_s.st = H_IDLE;
            end
         end
         default: begin
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.st <= H_IDLE;
         s.data <= LATCH_FILL;
      end else begin
         s <= next_s;
      end
   end

   // Outputs from registers
   assign wb_ack_o = s.wb_ack;
   assign wb_dat_o = s.wb_dat;
   assign bus.tbl_wr = s.tbl_wr;
   assign bus.table_page_pointer = s.addr[23:16];
   assign bus.tbl_offset = s.addr[15:0];
   assign bus.tbl_data = s.data;
   assign bus.reg_wr = s.reg_wr;
   assign bus.reg_sel = s.reg_sel;
   assign bus.reg_wdata = s.reg_wdata;
endmodule : fsps_core_host

// >>> verif/fsps_link_assertions.sv
// Checker for the link: table-write handshake, unlock and start, busy span.
// Assumes it sits beside the interface joining both ends, on one clock.
`timescale 1ns/1ps
module fsps_link_assertions (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Link signals
   input wire logic tbl_wr,
   input wire logic tbl_ack,
   input wire logic reg_wr,
   input wire logic reg_sel,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] ctrl_rdata,
   input wire logic stall
);
   import fsps_pkg::*;
   typedef struct packed {
      logic [1:0] key;
      logic [11:0] busy_n;
   } fsps_chk_t;
   fsps_chk_t st;
   fsps_chk_t next_st;
   logic go;
   logic op_ok;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Key progress as the sequencer sees it, and stall length
   always_comb begin
      next_st = st;
      if (tbl_wr && !tbl_ack) begin
         next_st.key = 2'h0;
      end
      if (reg_wr && !stall) begin
         if (reg_sel == REG_KEY && reg_wdata == KEY_FIRST) begin
            next_st.key = 2'h1;
         end else if (reg_sel == REG_KEY && reg_wdata == KEY_SECOND && st.key == 2'h1) begin
            next_st.key = 2'h2;
         end else begin
            next_st.key = 2'h0;
         end
      end
      next_st.busy_n = stall ? st.busy_n + {11'h000, ~&st.busy_n} : 12'h000;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // Start request and whether it qualifies
   assign go = reg_wr && !stall && reg_sel == REG_CTRL && reg_wdata[START_BIT];
   assign op_ok = reg_wdata[OP_WRITE_ENABLE_BIT] && st.key == 2'h2 &&
      (reg_wdata[3:0] == OP_ERASE ? reg_wdata[ERASE_BIT] :
      (reg_wdata[3:0] == OP_ROW || reg_wdata[3:0] == OP_WORD) && !reg_wdata[ERASE_BIT]);
   sequence ack_late_s;
      !tbl_ack ##1 tbl_ack;
   endsequence
   sequence busy_run_s;
      stall [*8];
   endsequence
   // Link properties
   start_go_a:
      assert property (go && op_ok |=> stall && ctrl_rdata[START_BIT] ##1 busy_run_s)
      else $error("accepted start did not stall the core");
   start_refused_a:
      assert property (go && !op_ok |=> !stall && !ctrl_rdata[START_BIT])
      else $error("unqualified start was not ignored");
   ack_delay_a:
      assert property ($rose(tbl_wr) && !stall |=> ack_late_s)
      else $error("table write ack not two cycles after request");
   ack_pulse_a:
      assert property (tbl_ack |=> !tbl_ack && !tbl_wr)
      else $error("table write ack or request overstayed");
   req_hold_a:
      assert property (tbl_wr && !tbl_ack |=> tbl_wr)
      else $error("table write request dropped before ack");
   load_busy_a:
      assert property (stall |-> !tbl_ack)
      else $error("latch load acknowledged while busy");
   start_flag_a:
      assert property (stall == ctrl_rdata[START_BIT])
      else $error("start flag and stall disagree");
   busy_max_a:
      assert property (st.busy_n <= ERASE_CYC + 12'h046)
      else $error("busy span too long");
   busy_min_a:
      assert property ($fell(stall) |-> $past(st.busy_n) + 12'h001 >= WORD_CYC)
      else $error("busy span too short");
   ctrl_bits_a:
      assert property ((ctrl_rdata & ~CTRL_MASK) == 16'h0000)
      else $error("unused control bits not zero");
endmodule : fsps_link_assertions

// >>> verif/flash_self_program_sequencer_tb_top.sv
// Bench: Wishbone stimulus on the core end, flash-side scoreboard,
// and a second sequencer end driven raw with broken unlock attempts and malformed start words.
`timescale 1ns/1ps
module flash_self_program_sequencer_tb_top;
   import fsps_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h00000000;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic [23:0] fl_addr;
   logic [23:0] fl_data;
   logic fl_prog;
   logic fl_erase;
   logic cfg_clr;
   logic op_done;
   int errors = 0;
   int check_count = 0;
   int dones = 0;
   logic [63:0] rd_q[$];
   logic [48:0] fl_q[$];
   logic [63:0] rx;
   logic [48:0] fx;
   logic [31:0] seed = 32'hE7F2;
   logic [23:0] row_d[64];
   fsps_if link();
   fsps_if raw();
   always #10 clk_i = ~clk_i;
   // Ends joined by the link, a raw-driven end, checker
   fsps_core_host fsps_core_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .bus(link));
   fsps_flash_seq fsps_flash_seq_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link),
      .fl_addr_o(fl_addr), .fl_data_o(fl_data), .fl_prog_o(fl_prog), .fl_erase_o(fl_erase),
      .cfg_cleared_o(cfg_clr), .op_done_o(op_done));
   fsps_flash_seq fsps_flash_seq_inst_b (.clk_i(clk_i), .rst_i(rst_i), .bus(raw),
      .fl_addr_o(), .fl_data_o(), .fl_prog_o(), .fl_erase_o(), .cfg_cleared_o(), .op_done_o());
   fsps_link_assertions fsps_link_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
      .tbl_wr(link.tbl_wr), .tbl_ack(link.tbl_ack), .reg_wr(link.reg_wr),
      .reg_sel(link.reg_sel), .reg_wdata(link.reg_wdata), .ctrl_rdata(link.ctrl_rdata),
      .stall(link.stall));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : lfsr
   task automatic mism(input string m);
      errors++;
      $display("mismatch at %0t: %s", $time, m);
   endtask : mism
   task automatic chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) mism(m);
   endtask : chk
   task automatic conclude();
      if (errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   // One classic Wishbone cycle; reads leave a masked expectation
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] m, input logic [31:0] e, output logic [31:0] r);
      int n;
      if (!we) rd_q.push_back({m, e});
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'h7;
      wb_wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) begin
         mism("no ack");
         conclude();
      end
      r = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb
   task automatic cmd(input logic [2:0] op, input logic [23:0] w, input logic [23:0] d);
      logic [31:0] r;
      wb(1'b1, HREG_ADDR, {16'h0000, w[14:0], 1'b0}, 32'h0, 32'h0, r);
      wb(1'b1, HREG_DATA, {8'h00, d}, 32'h0, 32'h0, r);
      wb(1'b1, HREG_CMD, {29'h0, op}, 32'h0, 32'h0, r);
   endtask : cmd
   // Poll busy; returns elapsed cycles
   task automatic idle(output int n);
      logic [31:0] r;
      time t0;
      t0 = $time;
      r = 32'h1;
      for (int k = 0; k < 3000 && r[0] !== 1'b0; k++) begin
         wb(1'b0, HREG_STATUS, 32'h0, 32'h0, 32'h0, r);
      end
      if (r[0] !== 1'b0) begin
         mism("busy never cleared");
         conclude();
      end
      n = int'(($time - t0) / CLK_PERIOD_NS);
   endtask : idle
   task automatic rw(input logic [16:0] v);
      @(posedge clk_i);
      raw.reg_wr <= 1'b1;
      raw.reg_sel <= v[16];
      raw.reg_wdata <= v[15:0];
      @(posedge clk_i);
      raw.reg_wr <= 1'b0;
   endtask : rw
   task automatic tst(input logic [16:0] a, input logic [16:0] b, input logic [16:0] d,
         input logic [15:0] s, input logic e);
      rw(a);
      rw(b);
      rw(d);
      rw({REG_CTRL, s});
      repeat (2) @(posedge clk_i);
      chk(raw.stall === e && raw.ctrl_rdata[START_BIT] === e, "raw start");
   endtask : tst
   // Read scoreboard
   always @(posedge clk_i) begin
      if (wb_ack === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0) begin
         rx = rd_q.pop_front();
         if (rx[63:32] != 32'h0) begin
            check_count++;
            if ((wb_rdat & rx[63:32]) !== rx[31:0]) mism("read data");
         end
      end
   end
   // Flash-side scoreboard and completion count
   always @(posedge clk_i) begin
      if (op_done === 1'b1) dones++;
      if (fl_prog === 1'b1 || fl_erase === 1'b1) begin
         check_count++;
         if (fl_q.size() == 0) begin
            mism("unexpected flash strobe");
         end else begin
            fx = fl_q.pop_front();
            if (fx[48] !== fl_erase || fx[47:24] !== fl_addr || (!fx[48] && fx[23:0] !== fl_data))
               mism("flash strobe");
         end
      end
   end
   // Main sequence
   initial begin
      logic [31:0] r;
      int c;
      int j;
      raw.tbl_wr = 1'b0;
      raw.table_page_pointer = 8'h00;
      raw.tbl_offset = 16'h0000;
      raw.tbl_data = 24'h000000;
      raw.reg_wr = 1'b0;
      raw.reg_sel = 1'b0;
      raw.reg_wdata = 16'h0000;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, HREG_DATA, 32'h0, 32'hFFFFFFFF, {8'h00, LATCH_FILL}, r);
      wb(1'b0, HREG_STATUS, 32'h0, 32'hFFFFFFFF, 32'h0, r);
      wb(1'b1, 8'h10, 32'hFFFFFFFF, 32'h0, 32'h0, r);
      wb(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF, 32'h0, r);
      seed = lfsr(seed);
      wb(1'b1, HREG_ADDR, seed, 32'h0, 32'h0, r);
      wb(1'b0, HREG_ADDR, 32'h0, 32'h00FFFFFF, {8'h00, seed[23:0]}, r);
      // Erase from an address inside the second block
      fl_q.push_back({1'b1, 24'h000200, 24'h000000});
      cmd(HCMD_ERASE, 24'h0003E8, 24'h000000);
      idle(c);
      chk(c >= ERASE_CYC, "erase too short");
      chk(cfg_clr === 1'b0, "config cleared early");
      // Row loaded out of order, one latch replaced, then programmed
      cmd(HCMD_LOAD, 24'h000165, 24'h123456);
      idle(c);
      for (int i = 0; i < ROW_WORDS; i++) begin
         j = (i + 38) % ROW_WORDS;
         seed = lfsr(seed);
         row_d[j] = seed[23:0];
         cmd(HCMD_LOAD, 24'h000140 + 24'(j), row_d[j]);
         idle(c);
      end
      for (int i = 0; i < ROW_WORDS; i++) begin
         fl_q.push_back({1'b0, 24'h000140 + 24'(i), row_d[i]});
      end
      cmd(HCMD_ROW, 24'h000165, 24'h000000);
      idle(c);
      chk(c >= ROW_CYC, "row too short");
      // Single word; a command while busy and an unknown code are ignored
      seed = lfsr(seed);
      cmd(HCMD_LOAD, 24'h00014D, seed[23:0]);
      idle(c);
      fl_q.push_back({1'b0, 24'h00014D, seed[23:0]});
      cmd(HCMD_WORD, 24'h00014D, 24'h000000);
      wb(1'b1, HREG_CMD, {29'h0, HCMD_ERASE}, 32'h0, 32'h0, r);
      wb(1'b0, HREG_STATUS, 32'h0, 32'hFFFF0007, 32'hC0030003, r);
      idle(c);
      chk(c + 8 >= WORD_CYC, "word too short");
      wb(1'b1, HREG_CMD, 32'h00000005, 32'h0, 32'h0, r);
      wb(1'b0, HREG_STATUS, 32'h0, 32'h80000007, 32'h0, r);
      // Last block erase clears the configuration words
      fl_q.push_back({1'b1, LAST_BLOCK, 24'h000000});
      cmd(HCMD_ERASE, LAST_BLOCK + 24'h000007, 24'h000000);
      idle(c);
      chk(cfg_clr === 1'b1, "config not cleared");
      chk(dones == 4 && fl_q.size() == 0, "operation count");
      // Raw end: broken unlock attempts, unlocked starts with bad control words, then a proper one
      tst(17'h04003, 17'h04003, 17'h04003, 16'hC003, 1'b0);
      tst(17'h04003, 17'h100AA, 17'h10055, 16'hC003, 1'b0);
      tst(17'h10055, 17'h04003, 17'h100AA, 16'hC003, 1'b0);
      tst(17'h00003, 17'h10055, 17'h100AA, 16'h8003, 1'b0);
      tst(17'h04041, 17'h10055, 17'h100AA, 16'hC041, 1'b0);
      tst(17'h04003, 17'h10055, 17'h100AA, 16'hC003, 1'b1);
      conclude();
   end
endmodule : flash_self_program_sequencer_tb_top
